// ==== test/rtc_core_sva.sv ====
// Port-level assertions for the real-time clock core
`timescale 1ns/1ns
module rtc_core_sva #(
  parameter logic CLK_CTRL_EN = 1'h1
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_ack_o,
  input wire logic ser_sel,
  input wire logic ser_clk,
  input wire logic ser_dout,
  input wire logic ser_dout_oe,
  input wire logic crystal_in,
  input wire logic crystal_out,
  input wire logic crystal_clock_out,
  input wire logic crystal_clock_out_oe,
  input wire logic shared_irq_n,
  input wire logic shared_irq_n_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  a_ack_bound: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |-> ##[1:3] wb_ack_o) else $error("request not acknowledged");
  a_clk_low: assert property (!crystal_clock_out)
    else $error("clock output data not low");
  a_pin_low: assert property (!shared_irq_n)
    else $error("interrupt pin data not low");
  a_osc_invert: assert property ($past(rst_b) |->
    crystal_out == !$past(crystal_in)) else $error("crystal drive wrong");
  a_clk_follow: assert property (crystal_clock_out_oe |->
    !$past(crystal_in)) else $error("clock output out of phase");
  a_clk_disable: assert property (CLK_CTRL_EN && wb_ack_o && wb_we_i &&
    wb_sel_i[0] && wb_adr_i == 8'h34 && wb_dat_i[7]
    |=> !crystal_clock_out_oe [*2]) else $error("clock output not off");
  a_irq_start: assert property ($rose(rst_b) |-> !shared_irq_n_oe)
    else $error("interrupt active after reset");
  a_dout_enable: assert property (ser_dout_oe |-> ser_sel)
    else $error("serial output driven while deselected");
  a_dout_start: assert property ($rose(ser_dout_oe) |-> ser_clk)
    else $error("read phase began away from a rising edge");
  a_dout_edge: assert property (ser_dout_oe && $past(ser_dout_oe) &&
    $changed(ser_dout) |-> !ser_clk) else $error("read bit moved early");

  cover property (wb_ack_o && wb_we_i);
  cover property ($rose(ser_dout_oe));
  cover property ($rose(shared_irq_n_oe));
endmodule : rtc_core_sva

bind rtc_core rtc_core_sva #(.CLK_CTRL_EN(CLK_CTRL_EN)) sva_u (
  .sys_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_i, .wb_sel_i, .wb_ack_o, .ser_sel, .ser_clk, .ser_dout,
  .ser_dout_oe, .crystal_in, .crystal_out, .crystal_clock_out,
  .crystal_clock_out_oe, .shared_irq_n, .shared_irq_n_oe
);

// ==== test/rtc_core_test.sv ====
// Self-checking bench for the real-time clock core
`timescale 1ns/1ns
module rtc_core_test;
  typedef struct {
    logic we;
    logic [7:0] adr;
    logic [7:0] dat;
    logic [7:0] exp;
  } rtc_row_t;
  rtc_row_t rows [18] = '{
    '{1'h0, 8'h38, 8'h00, 8'h08}, '{1'h0, 8'h34, 8'h00, 8'h01},
    '{1'h0, 8'h10, 8'h00, 8'h01}, '{1'h0, 8'h14, 8'h00, 8'h01},
    '{1'h1, 8'h04, 8'h59, 8'h00}, '{1'h0, 8'h04, 8'h00, 8'h59},
    '{1'h1, 8'h18, 8'h99, 8'h00}, '{1'h0, 8'h18, 8'h00, 8'h99},
    '{1'h1, 8'h0c, 8'h06, 8'h00}, '{1'h0, 8'h0c, 8'h00, 8'h06},
    '{1'h1, 8'h40, 8'h01, 8'h00}, '{1'h0, 8'h40, 8'h00, 8'h01},
    '{1'h1, 8'h3c, 8'h1f, 8'h00}, '{1'h0, 8'h3c, 8'h00, 8'h1f},
    '{1'h1, 8'h80, 8'hff, 8'h00}, '{1'h0, 8'h80, 8'h00, 8'h00},
    '{1'h1, 8'h1c, 8'h00, 8'h00}, '{1'h0, 8'h1c, 8'h00, 8'h00}};
  logic sys_clk = 1'h0;
  logic rst_b = 1'h0;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic crystal_in = 1'h0;
  logic xtal_stop = 1'h0;
  logic supply_below_high = 1'h0;
  logic supply_below_low = 1'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, irq, ser_sel, ser_clk, ser_din, ser_dout, ser_dout_oe;
  logic crystal_out, crystal_clock_out, crystal_clock_out_oe;
  logic shared_irq_n, shared_irq_n_oe;
  logic [7:0] rd;
  int err_count = 0;
  int n_checks = 0;

  always #4 sys_clk = ~sys_clk;

  // Fast stand-in crystal, one period every two system clocks
  always @(posedge sys_clk) begin
    if (!xtal_stop) begin
      crystal_in <= ~crystal_in;
    end
  end

  rtc_core #(.CLK_CTRL_EN(1'h1), .OSC_STOP_CYC(64)) dut_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq(irq), .ser_sel(ser_sel),
    .ser_clk(ser_clk), .ser_din(ser_din), .ser_dout(ser_dout),
    .ser_dout_oe(ser_dout_oe), .crystal_in(crystal_in),
    .crystal_out(crystal_out), .crystal_clock_out(crystal_clock_out),
    .crystal_clock_out_oe(crystal_clock_out_oe),
    .shared_irq_n(shared_irq_n), .shared_irq_n_oe(shared_irq_n_oe),
    .supply_below_high(supply_below_high),
    .supply_below_low(supply_below_low));

  rtc_host_model host_u (.sys_clk(sys_clk), .ser_sel(ser_sel),
    .ser_clk(ser_clk), .ser_din(ser_din), .ser_dout(ser_dout));

  task automatic chk(input string name, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [7:0] dat, input logic [3:0] sel,
                    output logic [7:0] v);
    @(posedge sys_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, dat};
    wb_sel_i <= sel;
    do begin
      @(posedge sys_clk);
    end while (wb_ack_o !== 1'h1);
    v = wb_dat_o[7:0];
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    chk("wb_hi", wb_dat_o[15:8], 8'h00);
  endtask : wb

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    logic [7:0] v;
    wb(1'h1, adr, dat, 4'hf, v);
  endtask : wr

  task automatic rdc(input logic [7:0] adr, input logic [7:0] exp);
    logic [7:0] v;
    wb(1'h0, adr, 8'h00, 4'hf, v);
    chk("reg", v, exp);
  endtask : rdc

  task automatic wait_irq(input logic exp);
    for (int i = 0; i < 8 && shared_irq_n_oe !== exp; i++) begin
      @(posedge sys_clk);
    end
    @(negedge sys_clk);
    chk("shared_irq_oe", {7'h0, shared_irq_n_oe}, {7'h0, exp});
  endtask : wait_irq

  task automatic chk_clk(input logic exp);
    while (crystal_in !== 1'h1) @(posedge sys_clk);
    while (crystal_in !== 1'h0) @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("clock_out_oe", {7'h0, crystal_clock_out_oe}, {7'h0, exp});
  endtask : chk_clk

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (90000) @(posedge sys_clk);
    err_count++;
    end_sim();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'h1;
    foreach (rows[i]) begin
      wb(rows[i].we, rows[i].adr, rows[i].dat, 4'hf, rd);
      if (!rows[i].we) chk("row", rd, rows[i].exp);
    end
    chk("irq", {7'h0, irq}, 8'h01);
    wr(8'h38, 8'h08);
    rdc(8'h38, 8'h00);
    chk("irq", {7'h0, irq}, 8'h00);
    xtal_stop <= 1'h1;
    repeat (100) @(posedge sys_clk);
    xtal_stop <= 1'h0;
    rdc(8'h38, 8'h08);
    wr(8'h38, 8'h08);
    supply_below_high <= 1'h1;
    rdc(8'h38, 8'h00);
    supply_below_low <= 1'h1;
    wr(8'h38, 8'h10);
    rdc(8'h38, 8'h10);
    supply_below_high <= 1'h0;
    supply_below_low <= 1'h0;
    repeat (4) @(posedge sys_clk);
    wr(8'h38, 8'h10);
    rdc(8'h38, 8'h00);
    wb(1'h1, 8'h04, 8'h11, 4'he, rd);
    rdc(8'h04, 8'h59);
    wr(8'h08, 8'h12);
    wr(8'h04, 8'h34);
    wr(8'h34, 8'h07);
    wait_irq(1'h0);
    wr(8'h2c, 8'h34);
    wr(8'h30, 8'h12);
    wait_irq(1'h1);
    rdc(8'h38, 8'h04);
    wr(8'h20, 8'h34);
    wr(8'h24, 8'h12);
    wr(8'h28, 8'h40);
    rdc(8'h38, 8'h06);
    wr(8'h38, 8'h06);
    wait_irq(1'h0);
    chk_clk(1'h1);
    wr(8'h34, 8'h87);
    chk_clk(1'h0);
    host_u.start();
    host_u.xfer(8'h08, 8, rd);
    host_u.xfer(8'h27, 8, rd);
    host_u.stop();
    rdc(8'h04, 8'h27);
    host_u.start();
    host_u.xfer(8'h0c, 8, rd);
    host_u.xfer(8'hff, 8, rd);
    host_u.stop();
    chk("ser_read", rd, 8'h27);
    host_u.start();
    host_u.xfer(8'hff, 3, rd);
    host_u.stop();
    host_u.start();
    host_u.xfer(8'h08, 8, rd);
    host_u.xfer(8'h15, 8, rd);
    host_u.stop();
    rdc(8'h04, 8'h15);
    // One divider second (65536 system clocks): leap-year February and a full day carry
    wr(8'h34, 8'h21);
    wr(8'h38, 8'h1f);
    wr(8'h04, 8'h59);
    wr(8'h08, 8'h23);
    wr(8'h10, 8'h28);
    wr(8'h14, 8'h02);
    wr(8'h18, 8'h00);
    wr(8'h00, 8'h59);
    repeat (65600) @(posedge sys_clk);
    rdc(8'h00, 8'h00);
    rdc(8'h04, 8'h00);
    rdc(8'h08, 8'h00);
    rdc(8'h10, 8'h29);
    rdc(8'h14, 8'h02);
    rdc(8'h38, 8'h01);
    wait_irq(1'h1);
    wr(8'h34, 8'h29);
    wait_irq(1'h0);
    chk("irq", {7'h0, irq}, 8'h01);
    end_sim();
  end
endmodule : rtc_core_test

// ==== test/rtc_host_model.sv ====
// Behavioural host driving the four-wire serial link
`timescale 1ns/1ns
module rtc_host_model #(
  parameter int HALF = 4
) (
  input wire logic sys_clk,
  output logic ser_sel,
  output logic ser_clk,
  output logic ser_din,
  input wire logic ser_dout
);
  initial begin
    ser_sel = 1'h0;
    ser_clk = 1'h0;
    ser_din = 1'h0;
  end

  task automatic start();
    @(posedge sys_clk);
    ser_sel <= 1'h1;
    repeat (HALF) @(posedge sys_clk);
  endtask : start

  task automatic stop();
    repeat (HALF) @(posedge sys_clk);
    ser_sel <= 1'h0;
    ser_din <= ~ser_din;
    repeat (2 * HALF) @(posedge sys_clk);
  endtask : stop

  // Data moves while the shift clock is low and is taken at its rise
  task automatic xfer(input logic [7:0] tx, input int n,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      ser_din <= tx[i];
      repeat (HALF) @(posedge sys_clk);
      rx[i] = ser_dout;
      ser_clk <= 1'h1;
      repeat (HALF) @(posedge sys_clk);
      ser_clk <= 1'h0;
    end
  endtask : xfer
endmodule : rtc_host_model

// ==== verilog/rtc_consts.svh ====
// Register indices, field positions, reset values and timing counts
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define RTC_REG_SEC 5'h00
`define RTC_REG_MIN 5'h01
`define RTC_REG_HOUR 5'h02
`define RTC_REG_DOW 5'h03
`define RTC_REG_DAY 5'h04
`define RTC_REG_MON 5'h05
`define RTC_REG_YEAR 5'h06
`define RTC_REG_ADJ 5'h07
`define RTC_REG_AWMIN 5'h08
`define RTC_REG_AWHOUR 5'h09
`define RTC_REG_AWDOW 5'h0a
`define RTC_REG_ADMIN 5'h0b
`define RTC_REG_ADHOUR 5'h0c
`define RTC_REG_CTRL 5'h0d
`define RTC_REG_STAT 5'h0e
`define RTC_REG_MASK 5'h0f
`define RTC_REG_CTRL2 5'h10

// ---------------------------------------------------------------
// Control fields and the hour PM bit
// ---------------------------------------------------------------
`define RTC_CTRL_H24 0
`define RTC_CTRL_AWEN 1
`define RTC_CTRL_ADEN 2
`define RTC_CTRL_HALT 3
`define RTC_CTRL_SEL_LO 4
`define RTC_CTRL_CKOFF 7
`define RTC_CTRL2_VDSL 0
`define RTC_HOUR_PM 5

// ---------------------------------------------------------------
// Status bits and reset values
// ---------------------------------------------------------------
`define RTC_ST_PER 0
`define RTC_ST_AW 1
`define RTC_ST_AD 2
`define RTC_ST_XSTP 3
`define RTC_ST_VDET 4
`define RTC_ST_RST 5'h08
`define RTC_CTRL_RST 8'h01
`define RTC_DAY_RST 8'h01

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define RTC_XTAL_HZ 32768
`define RTC_DIV_BASE 16'h0040
`define RTC_DIV_HALF 16'h403f
`define RTC_DIV_TERM 16'h803f
`define RTC_CLK_MHZ 125
`define RTC_OSC_STOP_US 1000

`endif

// ==== verilog/rtc_core.sv ====
// Real-time clock and calendar core with serial and Wishbone access
`timescale 1ns/1ns
`include "rtc_consts.svh"

module rtc_core #(
  parameter logic CLK_CTRL_EN = 1'b1,
  parameter int OSC_STOP_CYC = `RTC_OSC_STOP_US * `RTC_CLK_MHZ
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  input wire logic ser_sel,
  input wire logic ser_clk,
  input wire logic ser_din,
  output logic ser_dout,
  output logic ser_dout_oe,
  input wire logic crystal_in,
  output logic crystal_out,
  output logic crystal_clock_out,
  output logic crystal_clock_out_oe,
  output logic shared_irq_n,
  output logic shared_irq_n_oe,
  input wire logic supply_below_high,
  input wire logic supply_below_low
);
  import rtc_pkg::*;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  rtc_byte_t sec_ff, min_ff, hour_ff, dow_ff, day_ff, mon_ff, year_ff;
  rtc_byte_t adj_ff, awmin_ff, awhour_ff, awdow_ff, admin_ff, adhour_ff;
  rtc_byte_t ctrl_ff, ctrl2_ff;
  logic [4:0] st_ff, mask_ff;
  logic [15:0] div_ff;
  logic xin_d_ff, sclk_d_ff;
  logic [17:0] stop_cnt_ff;
  logic aw_match_d_ff, ad_match_d_ff;
  rtc_ser_state_t ser_st_ff;
  logic [2:0] bit_cnt_ff;
  rtc_byte_t sh_in_ff, sh_out_ff;
  rtc_idx_t ser_idx_ff;
  logic ser_wr_ff;
  rtc_idx_t ser_widx_ff;
  rtc_byte_t ser_wdat_ff;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic rtc_byte_t bcd_inc(input rtc_byte_t v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction : bcd_inc

  function automatic rtc_byte_t last_day(input rtc_byte_t m,
                                         input rtc_byte_t y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    unique case (m)
      8'h02: last_day = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
  endfunction : last_day

  function automatic rtc_byte_t rd_mux(input rtc_idx_t i);
    unique case (i)
      `RTC_REG_SEC: rd_mux = sec_ff;
      `RTC_REG_MIN: rd_mux = min_ff;
      `RTC_REG_HOUR: rd_mux = hour_ff;
      `RTC_REG_DOW: rd_mux = dow_ff;
      `RTC_REG_DAY: rd_mux = day_ff;
      `RTC_REG_MON: rd_mux = mon_ff;
      `RTC_REG_YEAR: rd_mux = year_ff;
      `RTC_REG_ADJ: rd_mux = adj_ff;
      `RTC_REG_AWMIN: rd_mux = awmin_ff;
      `RTC_REG_AWHOUR: rd_mux = awhour_ff;
      `RTC_REG_AWDOW: rd_mux = awdow_ff;
      `RTC_REG_ADMIN: rd_mux = admin_ff;
      `RTC_REG_ADHOUR: rd_mux = adhour_ff;
      `RTC_REG_CTRL: rd_mux = ctrl_ff;
      `RTC_REG_STAT: rd_mux = {3'h0, st_ff};
      `RTC_REG_MASK: rd_mux = {3'h0, mask_ff};
      `RTC_REG_CTRL2: rd_mux = ctrl2_ff;
      default: rd_mux = 8'h00;
    endcase
  endfunction : rd_mux

  // ---------------------------------------------------------------
  // Write port shared by Wishbone and the serial link
  // ---------------------------------------------------------------
  logic wb_req, wb_wr, wr_en;
  rtc_idx_t wr_idx;
  rtc_byte_t wr_dat;
  logic wb_hit;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~ser_wr_ff;
  assign wb_hit = (wb_adr_i[7:2] <= {1'b0, `RTC_REG_CTRL2});
  assign wb_wr = wb_req & wb_we_i & wb_sel_i[0] & wb_hit;
  assign wr_en = wb_wr | ser_wr_ff;
  assign wr_idx = ser_wr_ff ? ser_widx_ff : wb_adr_i[6:2];
  assign wr_dat = ser_wr_ff ? ser_wdat_ff : wb_dat_i[7:0];

  function automatic logic wr_to(input rtc_idx_t i);
    wr_to = wr_en && (wr_idx == i);
  endfunction : wr_to

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        wb_dat_o <= wb_hit ? {24'h00_0000, rd_mux(wb_adr_i[6:2])}
                           : 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // Crystal divider with adjustment
  // ---------------------------------------------------------------
  logic xedge, half_tick, sec_tick;
  assign xedge = crystal_in & ~xin_d_ff;
  assign half_tick = xedge && (div_ff == `RTC_DIV_HALF);
  assign sec_tick = xedge && (div_ff == `RTC_DIV_TERM);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      xin_d_ff <= 1'b0;
      div_ff <= `RTC_DIV_BASE;
    end else begin
      xin_d_ff <= crystal_in;
      if (wr_to(`RTC_REG_SEC)) begin
        div_ff <= `RTC_DIV_BASE;
      end else if (sec_tick) begin
        // Every ten seconds the reload shifts by the signed offset
        if (sec_ff[3:0] == 4'h9) begin
          div_ff <= `RTC_DIV_BASE + {{9{adj_ff[6]}}, adj_ff[6:0]};
        end else begin
          div_ff <= `RTC_DIV_BASE;
        end
      end else if (xedge) begin
        div_ff <= div_ff + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Time and calendar counters
  // ---------------------------------------------------------------
  logic h24, min_c, hr_c, day_c, mon_c, yr_c;
  logic hour_last;
  rtc_byte_t hr_inc;
  assign hr_inc = bcd_inc({3'h0, hour_ff[4:0]});
  assign h24 = ctrl_ff[`RTC_CTRL_H24];
  assign hour_last = h24 ? (hour_ff == 8'h23) : (hour_ff == 8'h31);
  assign min_c = sec_tick && (sec_ff == 8'h59);
  assign hr_c = min_c && (min_ff == 8'h59);
  assign day_c = hr_c && hour_last;
  assign mon_c = day_c && (day_ff == last_day(mon_ff, year_ff));
  assign yr_c = mon_c && (mon_ff == 8'h12);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sec_ff <= 8'h00;
      min_ff <= 8'h00;
      hour_ff <= 8'h00;
      dow_ff <= 8'h00;
      day_ff <= `RTC_DAY_RST;
      mon_ff <= `RTC_DAY_RST;
      year_ff <= 8'h00;
    end else begin
      if (wr_to(`RTC_REG_SEC)) begin
        sec_ff <= wr_dat;
      end else if (sec_tick) begin
        sec_ff <= min_c ? 8'h00 : bcd_inc(sec_ff);
      end
      if (wr_to(`RTC_REG_MIN)) begin
        min_ff <= wr_dat;
      end else if (min_c) begin
        min_ff <= hr_c ? 8'h00 : bcd_inc(min_ff);
      end
      if (wr_to(`RTC_REG_HOUR)) begin
        hour_ff <= wr_dat;
      end else if (hr_c) begin
        if (h24) begin
          hour_ff <= day_c ? 8'h00 : bcd_inc(hour_ff);
        end else if (hour_ff[4:0] == 5'h11) begin
          hour_ff <= {2'b00, ~hour_ff[`RTC_HOUR_PM], 5'h12};
        end else if (hour_ff[4:0] == 5'h12) begin
          hour_ff <= {2'b00, hour_ff[`RTC_HOUR_PM], 5'h01};
        end else begin
          hour_ff <= {2'b00, hour_ff[`RTC_HOUR_PM], hr_inc[4:0]};
        end
      end
      if (wr_to(`RTC_REG_DOW)) begin
        dow_ff <= wr_dat;
      end else if (day_c) begin
        dow_ff <= (dow_ff == 8'h06) ? 8'h00 : dow_ff + 8'h01;
      end
      if (wr_to(`RTC_REG_DAY)) begin
        day_ff <= wr_dat;
      end else if (day_c) begin
        day_ff <= mon_c ? `RTC_DAY_RST : bcd_inc(day_ff);
      end
      if (wr_to(`RTC_REG_MON)) begin
        mon_ff <= wr_dat;
      end else if (mon_c) begin
        mon_ff <= yr_c ? `RTC_DAY_RST : bcd_inc(mon_ff);
      end
      if (wr_to(`RTC_REG_YEAR)) begin
        year_ff <= wr_dat;
      end else if (yr_c) begin
        year_ff <= (year_ff == 8'h99) ? 8'h00 : bcd_inc(year_ff);
      end
    end
  end

  // ---------------------------------------------------------------
  // Settings
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      adj_ff <= 8'h00;
      awmin_ff <= 8'h00;
      awhour_ff <= 8'h00;
      awdow_ff <= 8'h00;
      admin_ff <= 8'h00;
      adhour_ff <= 8'h00;
      ctrl_ff <= `RTC_CTRL_RST;
      ctrl2_ff <= 8'h00;
      mask_ff <= 5'h00;
    end else begin
      if (wr_to(`RTC_REG_ADJ)) adj_ff <= wr_dat;
      if (wr_to(`RTC_REG_AWMIN)) awmin_ff <= wr_dat;
      if (wr_to(`RTC_REG_AWHOUR)) awhour_ff <= wr_dat;
      if (wr_to(`RTC_REG_AWDOW)) awdow_ff <= {1'b0, wr_dat[6:0]};
      if (wr_to(`RTC_REG_ADMIN)) admin_ff <= wr_dat;
      if (wr_to(`RTC_REG_ADHOUR)) adhour_ff <= wr_dat;
      if (wr_to(`RTC_REG_CTRL)) ctrl_ff <= wr_dat;
      if (wr_to(`RTC_REG_CTRL2)) ctrl2_ff <= {7'h00, wr_dat[0]};
      if (wr_to(`RTC_REG_MASK)) mask_ff <= wr_dat[4:0];
    end
  end

  // ---------------------------------------------------------------
  // Events, status and interrupts
  // ---------------------------------------------------------------
  logic per_ev, aw_match, ad_match, osc_stop, vdet;
  logic [4:0] st_set, st_clr;

  always_comb begin
    unique case (ctrl_ff[`RTC_CTRL_SEL_LO +: 3])
      3'h1: per_ev = half_tick | sec_tick;
      3'h2: per_ev = sec_tick;
      3'h3: per_ev = min_c;
      3'h4: per_ev = hr_c;
      3'h5: per_ev = day_c;
      3'h6: per_ev = mon_c;
      default: per_ev = 1'b0;
    endcase
  end

  assign aw_match = ctrl_ff[`RTC_CTRL_AWEN] && (min_ff == awmin_ff) &&
                    (hour_ff == awhour_ff) && awdow_ff[dow_ff[2:0]];
  assign ad_match = ctrl_ff[`RTC_CTRL_ADEN] && (min_ff == admin_ff) &&
                    (hour_ff == adhour_ff);
  assign osc_stop = (stop_cnt_ff == 18'(OSC_STOP_CYC - 1));
  assign vdet = ctrl2_ff[`RTC_CTRL2_VDSL] ? supply_below_low
                                          : supply_below_high;
  assign st_set = {vdet, osc_stop, ad_match & ~ad_match_d_ff,
                   aw_match & ~aw_match_d_ff, per_ev};
  assign st_clr = wr_to(`RTC_REG_STAT) ? wr_dat[4:0] : 5'h00;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stop_cnt_ff <= 18'h0_0000;
      aw_match_d_ff <= 1'b0;
      ad_match_d_ff <= 1'b0;
      st_ff <= `RTC_ST_RST;
      irq <= 1'b0;
      shared_irq_n_oe <= 1'b0;
    end else begin
      if (xedge) begin
        stop_cnt_ff <= 18'h0_0000;
      end else if (!osc_stop) begin
        stop_cnt_ff <= stop_cnt_ff + 18'h0_0001;
      end
      aw_match_d_ff <= aw_match;
      ad_match_d_ff <= ad_match;
      st_ff <= (st_ff & ~st_clr) | st_set;
      irq <= |(((st_ff & ~st_clr) | st_set) & mask_ff);
      shared_irq_n_oe <= (st_ff[`RTC_ST_PER] & ~ctrl_ff[`RTC_CTRL_HALT]) |
                         st_ff[`RTC_ST_AW] | st_ff[`RTC_ST_AD];
    end
  end

  assign shared_irq_n = 1'b0;

  // ---------------------------------------------------------------
  // Clock outputs
  // ---------------------------------------------------------------
  logic ck_en;
  assign ck_en = ~(CLK_CTRL_EN & ctrl_ff[`RTC_CTRL_CKOFF]);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      crystal_out <= 1'b0;
      crystal_clock_out_oe <= 1'b0;
    end else begin
      crystal_out <= ~crystal_in;
      crystal_clock_out_oe <= ck_en & ~crystal_in;
    end
  end

  assign crystal_clock_out = 1'b0;

  // ---------------------------------------------------------------
  // Serial link
  // ---------------------------------------------------------------
  logic sclk_rise, sclk_fall;
  rtc_byte_t byte_in;
  assign sclk_rise = ser_sel & ser_clk & ~sclk_d_ff;
  assign sclk_fall = ser_sel & ~ser_clk & sclk_d_ff;
  assign byte_in = {sh_in_ff[6:0], ser_din};

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_d_ff <= 1'b0;
      ser_st_ff <= SER_CMD;
      bit_cnt_ff <= 3'h0;
      sh_in_ff <= 8'h00;
      sh_out_ff <= 8'h00;
      ser_idx_ff <= 5'h00;
      ser_wr_ff <= 1'b0;
      ser_widx_ff <= 5'h00;
      ser_wdat_ff <= 8'h00;
      ser_dout <= 1'b0;
    end else begin
      sclk_d_ff <= ser_clk;
      ser_wr_ff <= 1'b0;
      if (!ser_sel) begin
        ser_st_ff <= SER_CMD;
        bit_cnt_ff <= 3'h0;
      end else if (sclk_rise) begin
        sh_in_ff <= byte_in;
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        if (bit_cnt_ff == 3'h7) begin
          unique case (ser_st_ff)
            SER_CMD: begin
              ser_st_ff <= byte_in[2] ? SER_RD : SER_WR;
              if (byte_in[2]) begin
                sh_out_ff <= rd_mux(byte_in[7:3]);
                ser_idx_ff <= byte_in[7:3] + 5'h01;
              end else begin
                ser_idx_ff <= byte_in[7:3];
              end
            end
            SER_WR: begin
              ser_wr_ff <= 1'b1;
              ser_widx_ff <= ser_idx_ff;
              ser_wdat_ff <= byte_in;
              ser_idx_ff <= ser_idx_ff + 5'h01;
            end
            SER_RD: begin
              sh_out_ff <= rd_mux(ser_idx_ff);
              ser_idx_ff <= ser_idx_ff + 5'h01;
            end
          endcase
        end
      end else if (sclk_fall && ser_st_ff == SER_RD) begin
        ser_dout <= sh_out_ff[7];
        sh_out_ff <= {sh_out_ff[6:0], 1'b0};
      end
    end
  end

  assign ser_dout_oe = ser_sel && (ser_st_ff == SER_RD);

endmodule : rtc_core

// ==== verilog/rtc_pkg.sv ====
// Types shared by the real-time clock core
package rtc_pkg;
  typedef logic [7:0] rtc_byte_t;
  typedef logic [4:0] rtc_idx_t;
  typedef enum logic [1:0] {
    SER_CMD,
    SER_WR,
    SER_RD
  } rtc_ser_state_t;
endpackage : rtc_pkg
